//--- include/nfd_pkg.sv
// Constants and types for the flash controller descriptor front end.
// Assumes a byte-wide register port clocked by the system clock.
package nfd_pkg;

    // ====================================================================
    // Descriptor slots
    // ====================================================================
    localparam int unsigned SLOT_COUNT = 8;
    localparam logic [2:0] SLOT_MAIN_PAGE = 3'h0;
    localparam logic [2:0] SLOT_CARD_PAGE = 3'h1;
    localparam logic [2:0] SLOT_SUB_ONE = 3'h2;
    localparam logic [2:0] SLOT_SUB_TWO = 3'h3;
    localparam logic [2:0] SLOT_FIRST_HIGH = 3'h4;
    localparam logic [2:0] SLOT_FIRST_LOW = 3'h5;
    localparam logic [2:0] SLOT_LAST_HIGH = 3'h6;
    localparam logic [2:0] SLOT_LAST_LOW = 3'h7;

    // ====================================================================
    // Field layout and reset values
    // ====================================================================
    localparam int unsigned PAGE_UNITS_LSB = 3;
    localparam logic [7:0] PAGE_FIELD_MASK = 8'hf8;
    localparam logic [7:0] SUB_ONE_MASK = 8'h7f;
    localparam logic [7:0] SUB_TWO_MASK = 8'h03;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] SUB_ONE_RESET = 8'h1e;
    localparam logic [7:0] SUB_TWO_RESET = 8'h00;
    localparam logic [7:0] PROTECT_RESET = 8'h00;
    localparam logic [1:0] MAX_DEV_WITH_CARD = 2'h2;

    // ====================================================================
    // Operations and states
    // ====================================================================
    typedef enum logic [1:0] {
        OP_READ_ID,
        OP_WRITE_BYTE,
        OP_ERASE_BLOCK,
        OP_NONE
    } nfd_op_t;

    typedef enum {
        ST_OFF,
        ST_LOADING,
        ST_IDLE,
        ST_RUN
    } nfd_state_t;

    typedef struct packed {
        logic [4:0] main_page_units;
        logic [4:0] card_page_units;
        logic [1:0] device_count_minus_one;
        logic [3:0] protected_device_bits;
        logic card_support_on;
        logic [1:0] pages_per_block_sel;
        logic [15:0] protect_first_block;
        logic [15:0] protect_last_block;
    } nfd_cfg_t;

endpackage : nfd_pkg

//--- core/nfd_descriptor.sv
// Flash controller descriptor loader and elementary operation issuer.
// Assumes software drives one-cycle write strobes synchronous to ref_clk_in.
`timescale 1ns/1ps
`default_nettype none

module nfd_descriptor (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic controller_clock_gate_on_in,
    input wire logic descriptor_port_wr_in,
    input wire logic [7:0] descriptor_port_data_in,
    input wire logic op_req_in,
    input wire logic [1:0] op_code_in,
    input wire logic [1:0] op_device_in,
    input wire logic [15:0] op_block_in,
    input wire logic op_done_in,
    output logic clock_enable_out,
    output logic configured_out,
    output logic running_flag_out,
    output logic op_issue_out,
    output logic [1:0] op_code_out,
    output logic [1:0] op_device_out,
    output logic op_illegal_out,
    output logic [2:0] slot_ptr_out,
    output nfd_pkg::nfd_cfg_t cfg_out
);

    // ====================================================================
    // State
    // ====================================================================
    logic gate_ff, nxt_gate;
    logic [2:0] slot_ff, nxt_slot;
    logic [7:0] slot_mem_ff [nfd_pkg::SLOT_COUNT];
    logic [7:0] nxt_mem [nfd_pkg::SLOT_COUNT];
    nfd_pkg::nfd_state_t state_ff, nxt_state;
    logic issue_ff, nxt_issue;
    logic illegal_ff, nxt_illegal;
    logic [1:0] code_ff, nxt_code;
    logic [1:0] dev_ff, nxt_dev;
    logic loaded_ff, nxt_loaded;
    // Registered so the status output comes straight from a flop
    logic run_ff, nxt_run;
    logic cfg_wr;
    logic dev_ok;
    logic blk_prot;
    logic [15:0] first_blk;
    logic [15:0] last_blk;

    // Writes only count while the controller clock is running
    assign cfg_wr = gate_ff && descriptor_port_wr_in;

    assign first_blk = {slot_mem_ff[nfd_pkg::SLOT_FIRST_HIGH],
                        slot_mem_ff[nfd_pkg::SLOT_FIRST_LOW]};
    assign last_blk = {slot_mem_ff[nfd_pkg::SLOT_LAST_HIGH],
                       slot_mem_ff[nfd_pkg::SLOT_LAST_LOW]};

    // ====================================================================
    // Operation checks
    // ====================================================================
    always_comb begin
        // Device index beyond count is illegal; card sits on device 3
        dev_ok = op_device_in
            <= slot_mem_ff[nfd_pkg::SLOT_SUB_ONE][6:5];
        // With the card on, the count only bounds the devices below it
        if (slot_mem_ff[nfd_pkg::SLOT_SUB_ONE][0] && op_device_in == 2'h3) begin
            dev_ok = 1'b1;
        end
        // Protection only applies to devices flagged as application
        blk_prot = slot_mem_ff[nfd_pkg::SLOT_SUB_ONE][1 + op_device_in]
            && op_block_in >= first_blk
            && op_block_in <= last_blk;
    end

    // ====================================================================
    // Next state
    // ====================================================================
    always_comb begin
        nxt_gate = controller_clock_gate_on_in;
        nxt_slot = slot_ff;
        nxt_mem = slot_mem_ff;
        nxt_state = state_ff;
        nxt_issue = 1'b0;
        nxt_illegal = 1'b0;
        nxt_code = code_ff;
        nxt_dev = dev_ff;
        nxt_loaded = loaded_ff;
        if (!gate_ff) begin
            nxt_slot = 3'h0;
            nxt_state = nfd_pkg::ST_OFF;
        end else if (cfg_wr) begin
            case (slot_ff)
                nfd_pkg::SLOT_MAIN_PAGE,
                nfd_pkg::SLOT_CARD_PAGE: begin
                    nxt_mem[slot_ff] = descriptor_port_data_in
                        & nfd_pkg::PAGE_FIELD_MASK;
                end
                nfd_pkg::SLOT_SUB_ONE: begin
                    nxt_mem[slot_ff] = descriptor_port_data_in
                        & nfd_pkg::SUB_ONE_MASK;
                end
                nfd_pkg::SLOT_SUB_TWO: begin
                    nxt_mem[slot_ff] = descriptor_port_data_in
                        & nfd_pkg::SUB_TWO_MASK;
                end
                default: begin
                    nxt_mem[slot_ff] = descriptor_port_data_in;
                end
            endcase
            nxt_slot = slot_ff + 3'h1;
            nxt_state = nfd_pkg::ST_LOADING;
            if (slot_ff == nfd_pkg::SLOT_LAST_LOW) begin
                nxt_loaded = 1'b1;
                nxt_state = nfd_pkg::ST_IDLE;
            end
        end else begin
            case (state_ff)
                nfd_pkg::ST_OFF: begin
                    nxt_state = loaded_ff ? nfd_pkg::ST_IDLE
                                          : nfd_pkg::ST_LOADING;
                end
                nfd_pkg::ST_LOADING: begin
                    nxt_state = nfd_pkg::ST_LOADING;
                end
                nfd_pkg::ST_IDLE: begin
                    // Only basic operations; sequences are software's job
                    if (op_req_in) begin
                        if (op_code_in == nfd_pkg::OP_NONE || !dev_ok
                            || (op_code_in != nfd_pkg::OP_READ_ID
                                && blk_prot)) begin
                            nxt_illegal = 1'b1;
                        end else begin
                            nxt_issue = 1'b1;
                            nxt_code = op_code_in;
                            nxt_dev = op_device_in;
                            nxt_state = nfd_pkg::ST_RUN;
                        end
                    end
                end
                nfd_pkg::ST_RUN: begin
                    if (op_req_in) begin
                        nxt_illegal = 1'b1;
                    end
                    if (op_done_in) begin
                        nxt_state = nfd_pkg::ST_IDLE;
                    end
                end
                default: begin
                    nxt_state = nfd_pkg::ST_OFF;
                end
            endcase
        end
        // Status is registered from the next state, so it matches state_ff with no lag
        nxt_run = (nxt_state == nfd_pkg::ST_RUN);
    end

    // ====================================================================
    // Loader registers
    // ====================================================================
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            gate_ff <= 1'b0;
            slot_ff <= 3'h0;
            loaded_ff <= 1'b0;
        end else begin
            gate_ff <= nxt_gate;
            slot_ff <= nxt_slot;
            loaded_ff <= nxt_loaded;
        end
    end

    // ====================================================================
    // Operation registers
    // ====================================================================
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_ff <= nfd_pkg::ST_OFF;
            run_ff <= 1'b0;
            issue_ff <= 1'b0;
            illegal_ff <= 1'b0;
            code_ff <= 2'h0;
            dev_ff <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            run_ff <= nxt_run;
            issue_ff <= nxt_issue;
            illegal_ff <= nxt_illegal;
            code_ff <= nxt_code;
            dev_ff <= nxt_dev;
        end
    end

    // ====================================================================
    // Descriptor storage
    // ====================================================================
    // Reset values differ per slot, so each slot is named here
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            slot_mem_ff[nfd_pkg::SLOT_MAIN_PAGE] <= nfd_pkg::PAGE_RESET;
            slot_mem_ff[nfd_pkg::SLOT_CARD_PAGE] <= nfd_pkg::PAGE_RESET;
            slot_mem_ff[nfd_pkg::SLOT_SUB_ONE] <= nfd_pkg::SUB_ONE_RESET;
            slot_mem_ff[nfd_pkg::SLOT_SUB_TWO] <= nfd_pkg::SUB_TWO_RESET;
            slot_mem_ff[nfd_pkg::SLOT_FIRST_HIGH] <= nfd_pkg::PROTECT_RESET;
            slot_mem_ff[nfd_pkg::SLOT_FIRST_LOW] <= nfd_pkg::PROTECT_RESET;
            slot_mem_ff[nfd_pkg::SLOT_LAST_HIGH] <= nfd_pkg::PROTECT_RESET;
            slot_mem_ff[nfd_pkg::SLOT_LAST_LOW] <= nfd_pkg::PROTECT_RESET;
        end else begin
            slot_mem_ff <= nxt_mem;
        end
    end

    // ====================================================================
    // Outputs
    // ====================================================================
    assign clock_enable_out = gate_ff;
    assign configured_out = loaded_ff;
    assign running_flag_out = run_ff;
    assign op_issue_out = issue_ff;
    assign op_code_out = code_ff;
    assign op_device_out = dev_ff;
    assign op_illegal_out = illegal_ff;
    assign slot_ptr_out = slot_ff;
    assign cfg_out.main_page_units =
        slot_mem_ff[nfd_pkg::SLOT_MAIN_PAGE][7:nfd_pkg::PAGE_UNITS_LSB];
    assign cfg_out.card_page_units =
        slot_mem_ff[nfd_pkg::SLOT_CARD_PAGE][7:nfd_pkg::PAGE_UNITS_LSB];
    assign cfg_out.device_count_minus_one =
        slot_mem_ff[nfd_pkg::SLOT_SUB_ONE][6:5];
    assign cfg_out.protected_device_bits =
        slot_mem_ff[nfd_pkg::SLOT_SUB_ONE][4:1];
    assign cfg_out.card_support_on = slot_mem_ff[nfd_pkg::SLOT_SUB_ONE][0];
    assign cfg_out.pages_per_block_sel =
        slot_mem_ff[nfd_pkg::SLOT_SUB_TWO][1:0];
    assign cfg_out.protect_first_block = first_blk;
    assign cfg_out.protect_last_block = last_blk;

endmodule : nfd_descriptor

`default_nettype wire

//--- test/nfd_checker.sv
// Port checker for the descriptor loader.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module nfd_checker (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic controller_clock_gate_on_in,
    input wire logic descriptor_port_wr_in,
    input wire logic [7:0] descriptor_port_data_in,
    input wire logic op_req_in,
    input wire logic [1:0] op_code_in,
    input wire logic [1:0] op_device_in,
    input wire logic [15:0] op_block_in,
    input wire logic op_done_in,
    input wire logic clock_enable_out,
    input wire logic configured_out,
    input wire logic running_flag_out,
    input wire logic op_issue_out,
    input wire logic [1:0] op_code_out,
    input wire logic [1:0] op_device_out,
    input wire logic op_illegal_out,
    input wire logic [2:0] slot_ptr_out,
    input wire nfd_pkg::nfd_cfg_t cfg_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    logic wr_ok;
    assign wr_ok = descriptor_port_wr_in && clock_enable_out;
    // ====================================================================
    // Descriptor loading
    // ====================================================================
    a_gated_ptr_zero: assert property (!clock_enable_out |=> slot_ptr_out == 3'h0)
        else $error("slot pointer not cleared while gated");
    a_ptr_advance: assert property (wr_ok |=> slot_ptr_out == $past(slot_ptr_out) + 3'h1)
        else $error("slot pointer did not advance");
    a_ptr_idle_hold: assert property (clock_enable_out && !descriptor_port_wr_in |=> $stable(slot_ptr_out))
        else $error("slot pointer moved without a write");
    a_main_page_slot: assert property (wr_ok && slot_ptr_out == 3'h0 |=> cfg_out.main_page_units == $past(descriptor_port_data_in[7:3]))
        else $error("slot zero not stored as main page units");
    a_sub_one_slot: assert property (wr_ok && slot_ptr_out == 3'h2 |=> {cfg_out.device_count_minus_one, cfg_out.protected_device_bits, cfg_out.card_support_on} == $past(descriptor_port_data_in[6:0]))
        else $error("slot two fields wrong");
    a_first_high_slot: assert property (wr_ok && slot_ptr_out == 3'h4 |=> cfg_out.protect_first_block[15:8] == $past(descriptor_port_data_in))
        else $error("slot four not first block high");
    a_last_low_wrap: assert property (wr_ok && slot_ptr_out == 3'h7 |=> cfg_out.protect_last_block[7:0] == $past(descriptor_port_data_in) && configured_out && slot_ptr_out == 3'h0)
        else $error("eighth byte did not finish the descriptor");
    // ====================================================================
    // Operations
    // ====================================================================
    a_issue_runs: assert property (op_issue_out |-> running_flag_out)
        else $error("issued operation without running flag");
    a_done_clears: assert property (running_flag_out && op_done_in |=> !running_flag_out)
        else $error("running flag stuck after completion");
    a_busy_refused: assert property (running_flag_out && op_req_in && !op_done_in |=> op_illegal_out && !op_issue_out)
        else $error("request while running not refused");
    a_bad_code: assert property (op_req_in && op_code_in == 2'h3 && !running_flag_out && configured_out && clock_enable_out && slot_ptr_out == 3'h0 |=> op_illegal_out ##1 !op_illegal_out)
        else $error("undefined operation not refused");
endmodule : nfd_checker
`default_nettype wire

//--- test/nfd_flash_model.sv
// Behavioural flash side: acknowledges each issued operation.
// Assumes op_issue_in is a one-cycle pulse; slow_in stretches the answer.
`timescale 1ns/1ps
`default_nettype none
module nfd_flash_model (
    input wire logic ref_clk_in,
    input wire logic op_issue_in,
    input wire logic slow_in,
    output logic op_done_out
);
    initial op_done_out = 1'b0;
    always @(posedge ref_clk_in) begin
        if (op_issue_in === 1'b1) begin
            repeat (slow_in ? 6 : 1) @(posedge ref_clk_in);
            #1 op_done_out = 1'b1;
            @(posedge ref_clk_in);
            #1 op_done_out = 1'b0;
        end
    end
endmodule : nfd_flash_model
`default_nettype wire

//--- test/nfd_descriptor_tb.sv
// Self-checking bench for the descriptor loader and operation issuer.
// Assumes the flash model answers every issued operation.
`timescale 1ns/1ps
`default_nettype none
module nfd_descriptor_tb;
    logic clk = 1'b0, rst_n = 1'b0, gate = 1'b0, wr = 1'b0, req = 1'b0;
    logic slow = 1'b0, done, ce, cfgd, run, iss, ill;
    logic [7:0] data = 8'h0;
    logic [1:0] code = 2'h0, dev = 2'h0, ocode, odev;
    logic [15:0] blk = 16'h0;
    logic [2:0] ptr;
    logic [63:0] d;
    nfd_pkg::nfd_cfg_t cfg;
    int n_mismatch = 0, comparisons = 0;
    // {code, device, block, refused}
    logic [20:0] tbl [8] = '{{4'h0, 16'h0015, 1'b0}, {4'h4, 16'h0005, 1'b0},
        {4'h8, 16'h0030, 1'b0}, {4'hc, 16'h0000, 1'b1},
        {4'h4, 16'h0015, 1'b1}, {4'h8, 16'h0020, 1'b1},
        {4'h5, 16'h0015, 1'b0}, {4'h2, 16'h0000, 1'b1}};
    always #12.5 clk = ~clk;
    nfd_descriptor DUT (.ref_clk_in(clk), .arst_n_in(rst_n),
        .controller_clock_gate_on_in(gate), .descriptor_port_wr_in(wr),
        .descriptor_port_data_in(data), .op_req_in(req), .op_code_in(code),
        .op_device_in(dev), .op_block_in(blk), .op_done_in(done),
        .clock_enable_out(ce), .configured_out(cfgd), .running_flag_out(run),
        .op_issue_out(iss), .op_code_out(ocode), .op_device_out(odev),
        .op_illegal_out(ill), .slot_ptr_out(ptr), .cfg_out(cfg));
    nfd_flash_model u_flash (.ref_clk_in(clk), .op_issue_in(iss),
        .slow_in(slow), .op_done_out(done));
    // ====================================================================
    // Helpers
    // ====================================================================
    function automatic nfd_pkg::nfd_cfg_t exp_cfg(input logic [63:0] b);
        return {b[7:3], b[15:11], b[22:21], b[20:17], b[16], b[25:24],
            b[39:32], b[47:40], b[55:48], b[63:56]};
    endfunction : exp_cfg
    task automatic chk8(input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask : chk8
    task automatic chk_cfg(input nfd_pkg::nfd_cfg_t e);
        comparisons++;
        if (cfg !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t exp %h got %h", $time, e, cfg);
        end
    endtask : chk_cfg
    task automatic load(input logic [63:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk) #1;
            wr = 1'b1;
            data = b[8*i +: 8];
        end
        @(posedge clk) #1;
        wr = 1'b0;
    endtask : load
    task automatic op(input logic [20:0] t);
        @(posedge clk) #1;
        {code, dev, blk} = t[20:1];
        req = 1'b1;
        @(posedge clk) #1;
        req = 1'b0;
        chk8({6'h0, t[0], ~t[0]}, {6'h0, ill, iss});
        if (!t[0]) chk8({4'h0, t[20:17]}, {4'h0, ocode, odev});
    endtask : op
    task automatic wait_idle;
        for (int i = 0; i < 40 && run !== 1'b0; i++) @(posedge clk) #1;
        chk8(8'h0, {7'h0, run});
    endtask : wait_idle
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    // ====================================================================
    // Tests
    // ====================================================================
    initial begin
        #(25 * 6000);
        n_mismatch++;
        close_out();
    end
    initial begin
        void'($urandom(32'h0283f487));
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        chk_cfg(exp_cfg(64'h001e0000));
        load({$urandom, $urandom}, 8);
        chk8(8'h0, {cfgd, 4'h0, ptr});
        chk_cfg(exp_cfg(64'h001e0000));
        $display("test gated done");
        gate = 1'b1;
        repeat (2) @(posedge clk);
        chk8(8'h1, {7'h0, ce});
        d = {$urandom, $urandom};
        load(d, 8);
        chk_cfg(exp_cfg(d));
        chk8(8'h80, {cfgd, run, 3'h0, ptr});
        load(64'h2000_1000_0122_0820, 8);
        chk_cfg(exp_cfg(64'h2000_1000_0122_0820));
        $display("test load done");
        foreach (tbl[i]) begin
            op(tbl[i]);
            wait_idle();
        end
        for (int i = 0; i < 4; i++) begin
            op({2'h0, 1'b0, 1'($urandom), 16'($urandom), 1'b0});
            wait_idle();
        end
        slow = 1'b1;
        op(21'h0);
        op(21'h1);
        wait_idle();
        $display("test ops done");
        load({$urandom, $urandom}, 3);
        gate = 1'b0;
        repeat (2) @(posedge clk) #1;
        chk8(8'h0, {5'h0, ptr});
        gate = 1'b1;
        repeat (2) @(posedge clk);
        d = {$urandom, $urandom};
        load(d, 8);
        chk_cfg(exp_cfg(d));
        load(64'h0000_0000_0021_0808, 8);
        op({2'h0, 2'h3, 16'h0000, 1'b0});
        wait_idle();
        op({2'h0, 2'h2, 16'h0000, 1'b1});
        $display("test regate done");
        close_out();
    end
endmodule : nfd_descriptor_tb
bind nfd_descriptor nfd_checker u_chk (.ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .controller_clock_gate_on_in(controller_clock_gate_on_in),
    .descriptor_port_wr_in(descriptor_port_wr_in),
    .descriptor_port_data_in(descriptor_port_data_in), .op_req_in(op_req_in),
    .op_code_in(op_code_in), .op_device_in(op_device_in),
    .op_block_in(op_block_in), .op_done_in(op_done_in),
    .clock_enable_out(clock_enable_out), .configured_out(configured_out),
    .running_flag_out(running_flag_out), .op_issue_out(op_issue_out),
    .op_code_out(op_code_out), .op_device_out(op_device_out),
    .op_illegal_out(op_illegal_out), .slot_ptr_out(slot_ptr_out),
    .cfg_out(cfg_out));
`default_nettype wire
